// file: core/hcp_host_port.sv
// holds the host CPU port: pin sampling, piece assembly, config words,
// both packet FIFOs and the interrupt pin.
// assumes host pins are asynchronous to mclk_in and the link logic is on it.
`timescale 1ns/1ps
`default_nettype none
module hcp_host_port #(
  parameter logic [31:0] VERSION_ID = 32'h0001_0000  // arbitrary value
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic master_reset_n_in,
  input wire logic host_select_n_in,
  input wire logic host_write_strobe_n_in,
  input wire logic host_read_strobe_n_in,
  input wire logic bus_width_select_in,
  input wire logic [6:0] host_addr_in,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe_n_out,
  output logic access_done_n_out,
  output logic access_done_oe_n_out,
  output logic irq_out_n_out,
  output logic link_power_status_out,
  input wire logic [30:0] irq_events_in,
  output logic tx_valid_out,
  output var hcp_pkg::hcp_tx_word_t tx_word_out,
  input wire logic tx_ready_in,
  input wire logic rx_valid_in,
  input wire logic [31:0] rx_data_in,
  output logic rx_ready_out
);
  import hcp_pkg::*;

  typedef enum logic {ST_IDLE, ST_DONE} hcp_state_t;

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  hcp_pins_t pins_s1_reg;
  hcp_pins_t pins_reg;
  logic mrst_s1_reg;
  logic mrst_reg;
  logic rst;

  always_ff @(posedge mclk_in) begin
    pins_s1_reg <= '{select_n: host_select_n_in, write_n: host_write_strobe_n_in,
                     read_n: host_read_strobe_n_in, wide: bus_width_select_in,
                     addr: host_addr_in, data: host_data_in};
    pins_reg <= pins_s1_reg;
    mrst_s1_reg <= master_reset_n_in;
    mrst_reg <= mrst_s1_reg;
  end

  assign rst = reset_in || !mrst_reg;

  // ****************************************************************
  // access decode
  // ****************************************************************
  hcp_state_t state_reg;
  logic [1:0] piece_reg;
  logic [6:0] last_addr_reg;
  logic last_dir_reg;
  logic [31:0] wbuf_reg;
  logic [31:0] rword_reg;
  logic [31:0] cfg_reg [CFG_WORDS];
  logic [31:0] int_reg;
  logic [31:0] mask_reg;
  logic start;
  logic is_wr;
  logic [1:0] cur_piece;
  logic last_piece;
  logic is_cfg;
  logic [3:0] cfg_idx;
  logic [31:0] word_full;
  logic [31:0] read_src;
  logic [31:0] rword;
  logic [4:0] shift;
  logic commit;
  logic tx_wr_ready;
  logic rx_rd_valid;
  logic [31:0] rx_rd_data;

  assign start = (state_reg == ST_IDLE) && !pins_reg.select_n
                 && (!pins_reg.write_n || !pins_reg.read_n);
  assign is_wr = !pins_reg.write_n;
  assign cur_piece = (pins_reg.addr == last_addr_reg && is_wr == last_dir_reg)
                     ? piece_reg : 2'h0;
  assign last_piece = pins_reg.wide ? (cur_piece == LAST_PIECE_WIDE)
                      : (cur_piece == LAST_PIECE_NARROW);
  assign is_cfg = (pins_reg.addr <= ADDR_CFG_LAST);
  assign cfg_idx = pins_reg.addr[5:2];
  // lowest piece first; the width select picks 16-bit or 8-bit lanes
  assign shift = pins_reg.wide ? {cur_piece[0], 4'h0} : {cur_piece, 3'h0};
  assign commit = start && is_wr && last_piece;

  always_comb begin
    word_full = wbuf_reg;
    if (pins_reg.wide) begin
      word_full[shift +: 16] = pins_reg.data;
    end else begin
      word_full[shift +: 8] = pins_reg.data[7:0];
    end
  end

  always_comb begin
    if (pins_reg.addr == ADDR_RX_READ) begin
      read_src = rx_rd_valid ? rx_rd_data : '0;
    end else if (!is_cfg) begin
      read_src = '0;
    end else if (cfg_idx == IDX_VERSION) begin
      read_src = VERSION_ID;
    end else if (cfg_idx == IDX_INT) begin
      read_src = int_reg;
    end else if (cfg_idx == IDX_MASK) begin
      read_src = mask_reg;
    end else begin
      read_src = cfg_reg[cfg_idx];
    end
  end

  // the whole word is latched on the first piece so later pieces stay coherent
  assign rword = (cur_piece == 2'h0) ? read_src : rword_reg;

  // ****************************************************************
  // handshake state
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      access_done_n_out <= 1'b1;
      host_data_oe_n_out <= 1'b1;
      host_data_out <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            // done comes 3 cycles after the strobe edge, inside both limits
            state_reg <= ST_DONE;
            access_done_n_out <= 1'b0;
            host_data_oe_n_out <= is_wr;
            host_data_out <= pins_reg.wide ? rword[shift +: 16] : {8'h00, rword[shift +: 8]};
          end
        end
        ST_DONE: begin
          // a new access needs select or both strobes released first
          if (pins_reg.select_n || (pins_reg.write_n && pins_reg.read_n)) begin
            state_reg <= ST_IDLE;
            access_done_n_out <= 1'b1;
            host_data_oe_n_out <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      access_done_oe_n_out <= 1'b1;
    end else begin
      access_done_oe_n_out <= pins_reg.select_n;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      piece_reg <= 2'h0;
      last_addr_reg <= '0;
      last_dir_reg <= 1'b0;
      wbuf_reg <= '0;
      rword_reg <= '0;
    end else if (start) begin
      last_addr_reg <= pins_reg.addr;
      last_dir_reg <= is_wr;
      piece_reg <= last_piece ? 2'h0 : 2'(cur_piece + 1'b1);
      wbuf_reg <= word_full;
      rword_reg <= rword;
    end
  end

  // ****************************************************************
  // config words and interrupts
  // ****************************************************************
  logic [30:0] int_clr;
  assign int_clr = (commit && is_cfg && cfg_idx == IDX_INT) ? word_full[30:0] : '0;

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_reg[i] <= (4'(i) == IDX_CONTROL) ? CONTROL_RESET : '0;
      end
      mask_reg <= '0;
    end else if (commit && is_cfg) begin
      if (cfg_idx == IDX_MASK) begin
        mask_reg <= word_full;
      end else if (cfg_idx != IDX_VERSION && cfg_idx != IDX_INT) begin
        cfg_reg[cfg_idx] <= word_full;
      end
    end
  end

  // an event in the clearing cycle keeps its bit set
  always_ff @(posedge mclk_in) begin
    if (rst) begin
      int_reg <= '0;
    end else begin
      int_reg[30:0] <= irq_events_in | (int_reg[30:0] & ~int_clr);
      int_reg[SUMMARY_BIT] <= |(int_reg[30:0] & mask_reg[30:0]);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst) begin
      irq_out_n_out <= 1'b1;
    end else begin
      irq_out_n_out <= !(mask_reg[SUMMARY_BIT] && int_reg[SUMMARY_BIT]);
    end
  end

  // power status is held high through master reset
  always_ff @(posedge mclk_in) begin
    if (rst) begin
      link_power_status_out <= 1'b1;
    end else begin
      link_power_status_out <= cfg_reg[IDX_CONTROL][LPS_BIT];
    end
  end

  // ****************************************************************
  // packet FIFOs
  // ****************************************************************
  // a word pushed into a full transmit FIFO is dropped; the host must pace
  hcp_tx_word_t tx_in;
  logic tx_push;
  assign tx_in = '{last: (pins_reg.addr == ADDR_TX_CONFIRM), data: word_full};
  assign tx_push = commit && (pins_reg.addr == ADDR_TX_WRITE
                              || pins_reg.addr == ADDR_TX_CONFIRM);

  hcp_fifo #(.WIDTH(WORD_W + 1), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .mclk_in(mclk_in),
    .reset_in(rst),
    .wr_valid_in(tx_push),
    .wr_data_in(tx_in),
    .wr_ready_out(tx_wr_ready),
    .rd_valid_out(tx_valid_out),
    .rd_data_out(tx_word_out),
    .rd_ready_in(tx_ready_in)
  );

  hcp_fifo #(.WIDTH(WORD_W), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .mclk_in(mclk_in),
    .reset_in(rst),
    .wr_valid_in(rx_valid_in),
    .wr_data_in(rx_data_in),
    .wr_ready_out(rx_ready_out),
    .rd_valid_out(rx_rd_valid),
    .rd_data_out(rx_rd_data),
    .rd_ready_in(start && !is_wr && last_piece
                 && pins_reg.addr == ADDR_RX_READ)
  );
endmodule
`default_nettype wire

// file: pkg/hcp_pkg.sv
// holds constants and carrier types of the host CPU port.
// assumes one 40 MHz system clock and a host that obeys the strobe timing.
// Overview of operation
// - each 32-bit word takes two or four accesses
// - width select high means 16-bit data bus
// - address picks config word, FIFO, write or confirm
// - accesses only count while select is low
// - done output goes low when access completes
// - done pin driven only while select is low
// - interrupt output low while masked interrupt pending
// - transmit FIFO feeds sender, receive FIFO feeds reads
// - transmit FIFO 24 words, receive FIFO 39
// - write done within 100 ns, strobe 60 ns
// - read done within 270 ns, strobe 60 ns
// - master reset low forces power status high
// - summary is OR of masked bits; enable gates only the interrupt output
package hcp_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int WR_DONE_MAX_NS = 100;
  localparam int RD_DONE_MAX_NS = 270;
  localparam int WR_DONE_MAX_CYC = WR_DONE_MAX_NS / CLK_PERIOD_NS;
  localparam int RD_DONE_MAX_CYC = RD_DONE_MAX_NS / CLK_PERIOD_NS;
  // ****************************************************************
  // sizes and address map
  // ****************************************************************
  localparam int WORD_W = 32;
  localparam int TX_DEPTH = 24;
  localparam int RX_DEPTH = 39;
  localparam int CFG_WORDS = 16;
  localparam logic [6:0] ADDR_CFG_LAST = 7'h3C;
  localparam logic [6:0] ADDR_TX_WRITE = 7'h40;
  localparam logic [6:0] ADDR_TX_CONFIRM = 7'h44;
  localparam logic [6:0] ADDR_RX_READ = 7'h48;
  localparam logic [3:0] IDX_VERSION = 4'h0;
  localparam logic [3:0] IDX_CONTROL = 4'h2;
  localparam logic [3:0] IDX_INT = 4'h3;
  localparam logic [3:0] IDX_MASK = 4'h4;
  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam logic [31:0] CONTROL_RESET = 32'hC600_2A01;
  localparam int LPS_BIT = 0;
  localparam int SUMMARY_BIT = 31;
  localparam logic [1:0] LAST_PIECE_WIDE = 2'h1;
  localparam logic [1:0] LAST_PIECE_NARROW = 2'h3;
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic select_n;
    logic write_n;
    logic read_n;
    logic wide;
    logic [6:0] addr;
    logic [15:0] data;
  } hcp_pins_t;
  typedef struct packed {
    logic last;
    logic [31:0] data;
  } hcp_tx_word_t;
endpackage

// file: core/hcp_fifo.sv
// holds a small synchronous FIFO with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module hcp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 24
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_ready_in
);
  localparam int PW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] FULL = PW'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW-1:0] count_reg;
  logic push;
  logic pop;

  assign wr_ready_out = (count_reg != FULL);
  assign rd_valid_out = (count_reg != '0);
  assign rd_data_out = mem[rd_ptr_reg];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_ready_in && rd_valid_out;

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data_in;
    end
  end

  // depth is not a power of two, so pointers wrap explicitly
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : PW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : PW'(rd_ptr_reg + 1'b1);
      end
      if (push && !pop) begin
        count_reg <= PW'(count_reg + 1'b1);
      end else if (pop && !push) begin
        count_reg <= PW'(count_reg - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/hcp_checker.sv
// holds port assertions of the host CPU port.
// assumes a bind to hcp_host_port and its single mclk_in domain.
`timescale 1ns/1ps
`default_nettype none
module hcp_checker (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic master_reset_n_in,
  input wire logic host_select_n_in,
  input wire logic host_write_strobe_n_in,
  input wire logic host_read_strobe_n_in,
  input wire logic bus_width_select_in,
  input wire logic [15:0] host_data_out,
  input wire logic host_data_oe_n_out,
  input wire logic access_done_n_out,
  input wire logic access_done_oe_n_out,
  input wire logic link_power_status_out,
  input wire logic tx_valid_out,
  input wire hcp_pkg::hcp_tx_word_t tx_word_out,
  input wire logic tx_ready_in
);
  import hcp_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // ****************************************************************
  // access timing and pin ownership
  // ****************************************************************
  property p_wr_done;
    $fell(host_write_strobe_n_in) && !host_select_n_in |-> ##[1:4] !access_done_n_out;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write done late");
  property p_rd_done;
    $fell(host_read_strobe_n_in) && !host_select_n_in |-> ##[1:10] !access_done_n_out;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read done late");
  // done may only follow a selected strobe seen through the synchroniser
  property p_done_src;
    $fell(access_done_n_out) |-> !$past(host_select_n_in, 2)
      && !($past(host_write_strobe_n_in, 2) && $past(host_read_strobe_n_in, 2));
  endproperty
  a_done_src: assert property (p_done_src) else $error("done without access");
  property p_done_hold;
    !access_done_n_out && !host_select_n_in
      && !(host_write_strobe_n_in && host_read_strobe_n_in) |=> !access_done_n_out;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped early");
  property p_done_oe;
    access_done_oe_n_out == $past(host_select_n_in, 3);
  endproperty
  a_done_oe: assert property (p_done_oe) else $error("done pin drive wrong");
  property p_rd_data;
    $fell(host_data_oe_n_out) |-> !access_done_n_out && !$past(host_read_strobe_n_in, 2);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("data driven off read");
  property p_narrow;
    !bus_width_select_in && !host_data_oe_n_out |-> host_data_out[15:8] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow read upper byte");
  property p_lps;
    !master_reset_n_in [*3] |=> link_power_status_out;
  endproperty
  a_lps: assert property (p_lps) else $error("power status low in reset");
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_word_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx word not held");
  c_wr: cover property ($fell(access_done_n_out) && !host_write_strobe_n_in);
  c_rd: cover property ($fell(host_data_oe_n_out));
  c_tx: cover property (tx_valid_out && tx_ready_in && tx_word_out.last);
endmodule
bind hcp_host_port hcp_checker chk_i (.mclk_in, .reset_in, .master_reset_n_in,
  .host_select_n_in, .host_write_strobe_n_in, .host_read_strobe_n_in, .bus_width_select_in,
  .host_data_out, .host_data_oe_n_out, .access_done_n_out, .access_done_oe_n_out,
  .link_power_status_out, .tx_valid_out, .tx_word_out, .tx_ready_in);
`default_nettype wire

// file: dv/hcp_host_model.sv
// holds a behavioural host processor that makes one piece access per call.
// assumes done_n_in and data_in already show the released pin levels.
`timescale 1ns/1ps
`default_nettype none
module hcp_host_model (
  input wire logic mclk_in,
  input wire logic done_n_in,
  input wire logic [15:0] data_in,
  output var hcp_pkg::hcp_pins_t pins_out
);
  import hcp_pkg::*;
  initial pins_out = '{1'b1, 1'b1, 1'b1, 1'b1, 7'h00, 16'h0000};
  // strobe held until done is seen, which also keeps it past the 60 ns minimum
  task automatic acc(input logic wr, input logic wide, input logic [6:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic ok);
    int n;
    @(negedge mclk_in);
    pins_out.select_n = 1'b0;
    pins_out.wide = wide;
    pins_out.addr = a;
    // a read leaves the host side toggling so a stale value never matches
    pins_out.data = wr ? d : ~pins_out.data;
    pins_out.write_n = !wr;
    pins_out.read_n = wr;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (done_n_in !== 1'b0 && n < 20);
    q = data_in;
    @(negedge mclk_in);
    pins_out.write_n = 1'b1;
    pins_out.read_n = 1'b1;
    while (done_n_in !== 1'b1 && n < 40) begin
      @(negedge mclk_in);
      n++;
    end
    pins_out.select_n = 1'b1;
    ok = n < 20;
  endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// holds the self-checking bench of the host CPU port.
// assumes the host model drives the pins and the bench plays the link side.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hcp_pkg::*;
  localparam logic [31:0] VER = 32'h5A5A_0003;  // arbitrary value
  logic mclk_in = 0, reset_in = 1, master_reset_n_in = 1, tx_ready_in = 0, rx_valid_in = 0;
  logic host_data_oe_n_out, access_done_n_out, access_done_oe_n_out, irq_out_n_out;
  logic link_power_status_out, tx_valid_out, rx_ready_out;
  logic [15:0] host_data_out;
  logic [30:0] irq_events_in = '0;
  logic [31:0] rx_data_in = '0;
  hcp_tx_word_t tx_word_out;
  hcp_pins_t pins;
  wire logic done_wire = access_done_oe_n_out ? 1'b1 : access_done_n_out;
  // a released data bus shows the inverse so a missing drive never matches
  wire logic [15:0] data_wire = host_data_oe_n_out ? ~host_data_out : host_data_out;
  int n_errors = 0, n_compared = 0;
  initial forever #12.5 mclk_in = ~mclk_in;
  hcp_host_port #(.VERSION_ID(VER)) uut (.mclk_in, .reset_in, .master_reset_n_in,
    .host_select_n_in(pins.select_n), .host_write_strobe_n_in(pins.write_n),
    .host_read_strobe_n_in(pins.read_n), .bus_width_select_in(pins.wide),
    .host_addr_in(pins.addr), .host_data_in(pins.data), .host_data_out, .host_data_oe_n_out,
    .access_done_n_out, .access_done_oe_n_out, .irq_out_n_out, .link_power_status_out,
    .irq_events_in, .tx_valid_out, .tx_word_out, .tx_ready_in, .rx_valid_in, .rx_data_in,
    .rx_ready_out);
  hcp_host_model host (.mclk_in, .done_n_in(done_wire), .data_in(data_wire),
    .pins_out(pins));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // whole word in two or four pieces, lowest piece first
  task automatic xfer(input logic wr, input logic wide, input logic [6:0] a,
      input logic [31:0] d, output logic [31:0] q);
    logic [15:0] r;
    logic ok;
    q = '0;
    for (int k = 0; k < (wide ? 2 : 4); k++) begin
      host.acc(wr, wide, a, wide ? d[k*16 +: 16] : {8'h00, d[k*8 +: 8]}, r, ok);
      if (!ok) begin
        n_errors++;
        finish_test();
      end
      if (wide) q[k*16 +: 16] = r;
      else q[k*8 +: 8] = r[7:0];
    end
  endtask
  task automatic pulse(input logic [30:0] v);
    @(negedge mclk_in) irq_events_in = v;
    @(negedge mclk_in) irq_events_in = '0;
    repeat (4) @(negedge mclk_in);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic s_cfg();
    logic [31:0] q;
    logic [15:0] r;
    logic ok;
    xfer(0, 1, 7'h00, 0, q);
    chk("version", VER, q);
    xfer(0, 0, 7'h08, 0, q);
    chk("control", CONTROL_RESET, q);
    chk("lps", 1, link_power_status_out);
    xfer(1, 0, 7'h14, 32'hA1B2_C3D4, q);
    host.acc(1, 1, 7'h14, 16'h5555, r, ok);
    xfer(0, 1, 7'h14, 0, q);
    chk("cfg 14h", 32'hA1B2_C3D4, q);
    xfer(1, 1, 7'h08, 32'hC600_2A00, q);
    chk("lps off", 0, link_power_status_out);
    xfer(1, 1, 7'h60, 32'hFFFF_FFFF, q);
    xfer(0, 1, 7'h60, 0, q);
    chk("unmapped", 0, q);
  endtask
  task automatic s_irq();
    logic [31:0] q;
    xfer(1, 1, 7'h10, 32'h8000_0005, q);
    pulse(31'h4);
    chk("irq on", 0, irq_out_n_out);
    xfer(0, 1, 7'h0C, 0, q);
    chk("int word", 32'h8000_0004, q);
    xfer(1, 1, 7'h0C, 32'h0000_0004, q);
    repeat (4) @(negedge mclk_in);
    chk("irq clear", 1, irq_out_n_out);
    pulse(31'h8);
    chk("irq unmasked", 1, irq_out_n_out);
    xfer(1, 1, 7'h10, 32'h0000_0002, q);
    pulse(31'h2);
    chk("irq gated", 1, irq_out_n_out);
    xfer(0, 0, 7'h0C, 0, q);
    chk("summary", 32'h8000_000A, q);
  endtask
  task automatic s_tx();
    logic [31:0] q;
    for (int i = 0; i < 25; i++) xfer(1, 1, i == 23 ? 7'h44 : 7'h40, 32'h1000_0000 + i, q);
    @(negedge mclk_in) tx_ready_in = 1;
    for (int i = 0; i < 24; i++) begin
      chk("tx word", {i == 23, 32'h1000_0000 + i}, tx_word_out);
      @(negedge mclk_in);
    end
    chk("tx empty", 0, tx_valid_out);
    tx_ready_in = 0;
  endtask
  task automatic s_rx();
    logic [31:0] q;
    int n;
    @(negedge mclk_in) rx_valid_in = 1;
    for (n = 0; n < 40 && rx_ready_out === 1'b1; n++) begin
      rx_data_in = 32'h2000_0000 + n;
      @(negedge mclk_in);
    end
    rx_valid_in = 0;
    chk("rx depth", 39, n);
    for (int i = 0; i < 39; i++) begin
      xfer(0, i[0], 7'h48, 0, q);
      chk("rx word", 32'h2000_0000 + i, q);
    end
    xfer(0, 1, 7'h48, 0, q);
    chk("rx empty", 0, q);
  endtask
  task automatic s_mrst();
    logic [31:0] q;
    @(negedge mclk_in) master_reset_n_in = 0;
    repeat (4) @(negedge mclk_in);
    chk("lps reset", 1, link_power_status_out);
    master_reset_n_in = 1;
    repeat (5) @(negedge mclk_in);
    xfer(0, 1, 7'h08, 0, q);
    chk("control again", CONTROL_RESET, q);
  endtask
  initial begin
    repeat (8) @(negedge mclk_in);
    reset_in = 0;
    repeat (4) @(negedge mclk_in);
    s_cfg();
    s_irq();
    s_tx();
    s_rx();
    s_mrst();
    finish_test();
  end
endmodule
`default_nettype wire
